// [ifd_pkg.sv]
package ifd_pkg;

    // Widths of the fetch path
    localparam int PC_W       = 21;
    localparam int WORD_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int LIT_W      = 12;

    // Byte steps for one and two instruction words
    localparam logic [20:0] STEP_ONE_WORD = 21'h000002;
    localparam logic [20:0] STEP_TWO_WORD = 21'h000004;
    localparam logic [20:0] RESET_PC      = 21'h000000;

    // Second-word marker in the top nibble
    localparam logic [3:0]  SECOND_MARK   = 4'hF;

    // First-word opcode fields: goto and load bits 15:8, call bits 15:9 (bit 8 is the fast flag), move bits 15:12
    localparam logic [6:0]  OPC_CALL      = 7'h76;
    localparam logic [7:0]  OPC_GOTO      = 8'hEF;
    localparam logic [3:0]  OPC_MOVE_FF   = 4'hC;
    localparam logic [7:0]  OPC_LOAD_FSR  = 8'hEE;
    localparam logic [1:0]  LFSR_SUB      = 2'h0;

    // Relative branch opcodes
    localparam logic [4:0]  OPC_BRA       = 5'h1A;
    localparam logic [4:0]  OPC_RCALL     = 5'h1B;
    localparam logic [4:0]  OPC_BCOND     = 5'h1C;

    // Kinds of instruction the decoder reports
    typedef enum logic [2:0] {
        IFD_K_SINGLE,
        IFD_K_CALL,
        IFD_K_GOTO,
        IFD_K_MOVE_FF,
        IFD_K_LOAD_FSR,
        IFD_K_BRANCH,
        IFD_K_NOP
    } ifd_kind_e;

    // Fully decoded instruction handed to the sequencer
    typedef struct packed {
        ifd_kind_e          kind;
        logic [WORD_W-1:0]  first_word;
        logic [LIT_W-1:0]   literal;
        logic [PC_W-1:0]    target;
    } ifd_decoded_s;

endpackage : ifd_pkg

// [ifd_word_class.sv]
`timescale 1ns/1ps
`default_nettype none

// Classifies one instruction word; purely combinational
module ifd_word_class (
    // Word under test
    input  wire logic [15:0] word,
    // Classification
    output logic             is_first_of_pair,
    output logic             is_second_mark,
    output logic             is_rel_branch,
    output ifd_pkg::ifd_kind_e pair_kind
);

    // Opcode match terms
    wire logic hit_call  = (word[15:9] == ifd_pkg::OPC_CALL);
    wire logic hit_goto  = (word[15:8] == ifd_pkg::OPC_GOTO);
    wire logic hit_move  = (word[15:12] == ifd_pkg::OPC_MOVE_FF);
    wire logic hit_lfsr  = (word[15:8] == ifd_pkg::OPC_LOAD_FSR) && (word[7:6] == ifd_pkg::LFSR_SUB);

    // Exactly four opcodes open a pair
    assign is_first_of_pair = hit_call | hit_goto | hit_move | hit_lfsr;
    assign is_second_mark   = (word[15:12] == ifd_pkg::SECOND_MARK);
    assign is_rel_branch    = (word[15:11] == ifd_pkg::OPC_BRA) || (word[15:11] == ifd_pkg::OPC_RCALL)
                            || (word[15:11] == ifd_pkg::OPC_BCOND);
    assign pair_kind = hit_call ? ifd_pkg::IFD_K_CALL :
                       hit_goto ? ifd_pkg::IFD_K_GOTO :
                       hit_move ? ifd_pkg::IFD_K_MOVE_FF :
                       hit_lfsr ? ifd_pkg::IFD_K_LOAD_FSR : ifd_pkg::IFD_K_SINGLE;

endmodule // ifd_word_class

`default_nettype wire

// [ifd_fetch_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module ifd_fetch_decode (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    // Program memory byte port
    output logic [20:0]               mem_addr_ff,
    input  wire logic [7:0]           mem_rdata,
    // Sequencer control
    input  wire logic                 skip_next,
    input  wire logic                 take_branch,
    input  wire logic                 load_target,
    input  wire logic [20:0]          target_pc,
    // Decoded instruction out
    output logic                      dec_valid_ff,
    output ifd_pkg::ifd_decoded_s     dec_ff,
    output logic [20:0]               pc_ff
);

    typedef enum logic [1:0] {
        IFD_ST_LOW,
        IFD_ST_HIGH,
        IFD_ST_EXEC
    } ifd_state_e;

    // Sign extend a word count and scale it to bytes
    function automatic logic [20:0] word_off_to_bytes(input logic [10:0] words);
        logic [20:0] ext;
        ext = {{10{words[10]}}, words};
        return {ext[19:0], 1'b0};
    endfunction

    ifd_state_e             state_ff;
    logic [7:0]             low_byte_ff;
    logic                   pend_pair_ff;
    logic                   skip_pend_ff;
    logic [15:0]            held_first_ff;
    ifd_pkg::ifd_kind_e     held_kind_ff;
    logic [20:0]            fetch_pc_ff;

    // Current word and its classification
    wire logic [15:0]       cur_word = {mem_rdata, low_byte_ff};
    logic                   w_first;
    logic                   w_second;
    logic                   w_branch;
    ifd_pkg::ifd_kind_e     w_kind;

    ifd_word_class u_class (
        .word             (cur_word),
        .is_first_of_pair (w_first),
        .is_second_mark   (w_second),
        .is_rel_branch    (w_branch),
        .pair_kind        (w_kind)
    );

    // Address arithmetic; LSB forced to zero keeps word alignment
    wire logic [20:0] seq_pc     = {fetch_pc_ff[20:1] + 20'h00001, 1'b0};
    wire logic [19:0] abs_word   = {cur_word[11:0], held_first_ff[7:0]};  // High twelve bits ride in the second word
    wire logic [20:0] abs_pc     = {abs_word[19:0], 1'b0};
    wire logic [10:0] rel_words  = (cur_word[15:12] == 4'hD) ? cur_word[10:0] : {{3{cur_word[7]}}, cur_word[7:0]};
    wire logic [20:0] rel_pc     = seq_pc + word_off_to_bytes(rel_words);
    wire logic [20:0] ext_target = {target_pc[20:1], 1'b0};

    // Pairing: only a second word right after its first is an operand
    wire logic is_operand = pend_pair_ff && w_second;
    wire logic is_orphan  = !pend_pair_ff && w_second;
    wire logic opens_pair = !pend_pair_ff && w_first && !skip_pend_ff;

    // Decoded record for the word just assembled
    ifd_pkg::ifd_decoded_s nxt_dec;
    always_comb begin
        nxt_dec            = '0;
        nxt_dec.first_word = cur_word;
        nxt_dec.kind       = ifd_pkg::IFD_K_SINGLE;
        if (skip_pend_ff) begin
            nxt_dec.kind = ifd_pkg::IFD_K_NOP;
        end else if (is_operand) begin
            nxt_dec.kind       = held_kind_ff;
            nxt_dec.first_word = held_first_ff;
            nxt_dec.literal    = cur_word[11:0];
            nxt_dec.target     = abs_pc;
        end else if (is_orphan) begin
            nxt_dec.kind = ifd_pkg::IFD_K_NOP;
        end else if (w_branch) begin
            nxt_dec.kind   = ifd_pkg::IFD_K_BRANCH;
            nxt_dec.target = rel_pc;
        end
    end

    // Next fetch address after the current word is consumed
    logic [20:0] nxt_fetch_pc;
    always_comb begin
        nxt_fetch_pc = seq_pc;
        if (load_target) begin
            nxt_fetch_pc = ext_target;
        end else if (is_operand && !skip_pend_ff &&
                     (held_kind_ff == ifd_pkg::IFD_K_CALL || held_kind_ff == ifd_pkg::IFD_K_GOTO)) begin
            nxt_fetch_pc = abs_pc;
        end else if (w_branch && !skip_pend_ff && take_branch) begin
            nxt_fetch_pc = rel_pc;
        end
    end

    // Byte fetch sequencer: low byte, high byte, then decode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= IFD_ST_LOW;
            mem_addr_ff  <= ifd_pkg::RESET_PC;
            fetch_pc_ff  <= ifd_pkg::RESET_PC;
            low_byte_ff  <= 8'h00;
        end else begin
            unique case (state_ff)
                IFD_ST_LOW: begin
                    low_byte_ff <= mem_rdata;
                    mem_addr_ff <= {fetch_pc_ff[20:1], 1'b1};
                    state_ff    <= IFD_ST_HIGH;
                end
                IFD_ST_HIGH: begin
                    state_ff <= IFD_ST_EXEC;
                end
                IFD_ST_EXEC: begin
                    fetch_pc_ff <= nxt_fetch_pc;
                    mem_addr_ff <= nxt_fetch_pc;
                    state_ff    <= IFD_ST_LOW;
                end
            endcase
        end
    end

    // Pair tracking and skip bookkeeping
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend_pair_ff  <= 1'b0;
            skip_pend_ff  <= 1'b0;
            held_first_ff <= 16'h0000;
            held_kind_ff  <= ifd_pkg::IFD_K_SINGLE;
        end else if (state_ff == IFD_ST_EXEC) begin
            // A skip drops only one word; an orphaned second word follows as a no-op
            skip_pend_ff <= skip_next && !opens_pair && !load_target;
            pend_pair_ff <= opens_pair && !load_target;
            if (opens_pair) begin
                held_first_ff <= cur_word;
                held_kind_ff  <= w_kind;
            end
        end
    end

    // Decoded output, one pulse per consumed word; first words of pairs wait
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dec_valid_ff <= 1'b0;
            dec_ff       <= '0;
            pc_ff        <= ifd_pkg::RESET_PC;
        end else begin
            dec_valid_ff <= (state_ff == IFD_ST_EXEC) && !opens_pair;
            if (state_ff == IFD_ST_EXEC) begin
                dec_ff <= nxt_dec;
                pc_ff  <= nxt_fetch_pc;
            end
        end
    end

endmodule // ifd_fetch_decode

`default_nettype wire

// [ifd_fetch_decode_props.sv]
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the fetch/decode block
module ifd_fetch_decode_props (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  arst_n,
    // Watched outputs
    input wire logic [20:0]           mem_addr_ff,
    input wire logic                  dec_valid_ff,
    input wire ifd_pkg::ifd_decoded_s dec_ff,
    input wire logic [20:0]           pc_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Alignment, byte order and pacing
    pc_aligned_a: assert property (pc_ff[0] == 1'b0) else $error("pc odd");
    byte_pair_a: assert property ($rose(mem_addr_ff[0]) |-> mem_addr_ff == $past(mem_addr_ff) + 21'h000001)
        else $error("high byte not at next address");
    pulse_gap_a: assert property (dec_valid_ff |=> !dec_valid_ff [*2]) else $error("words closer than 3 cycles");
    next_fetch_a: assert property (dec_valid_ff |-> mem_addr_ff == pc_ff) else $error("fetch not at pc");
    // A lone second word only steps one word
    orphan_nop_a: assert property (dec_valid_ff && dec_ff.kind == ifd_pkg::IFD_K_NOP
        |-> pc_ff == $past(pc_ff, 3) + ifd_pkg::STEP_ONE_WORD) else $error("nop moved pc wrongly");
    pair_step_a: assert property (dec_valid_ff && dec_ff.kind inside {ifd_pkg::IFD_K_MOVE_FF, ifd_pkg::IFD_K_LOAD_FSR}
        |-> pc_ff == $past(pc_ff, 6) + ifd_pkg::STEP_TWO_WORD) else $error("pair step not four");
    abs_target_a: assert property (dec_valid_ff && dec_ff.kind inside {ifd_pkg::IFD_K_CALL, ifd_pkg::IFD_K_GOTO}
        |-> pc_ff == {dec_ff.literal, dec_ff.first_word[7:0], 1'b0}) else $error("jump target wrong");
    kind_opcode_a: assert property (dec_valid_ff |-> (dec_ff.kind != ifd_pkg::IFD_K_MOVE_FF
        || dec_ff.first_word[15:12] == ifd_pkg::OPC_MOVE_FF) && (dec_ff.kind != ifd_pkg::IFD_K_GOTO
        || dec_ff.first_word[15:8] == ifd_pkg::OPC_GOTO)) else $error("kind does not match opcode");
endmodule // ifd_fetch_decode_props

`default_nettype wire

// [ifd_prog_mem.sv]
`timescale 1ns/1ps
`default_nettype none

// Byte-wide program memory, combinational read
module ifd_prog_mem (
    // Fetch port
    input wire logic [20:0] mem_addr,
    output logic     [7:0]  mem_rdata
);
    logic [7:0] bytes_q [64];

    // Words stored low byte even, high byte odd; space beyond reads zero so a far jump fetches plain words
    assign mem_rdata = (mem_addr < 21'h000040) ? bytes_q[mem_addr[5:0]] : 8'h00;
endmodule // ifd_prog_mem

`default_nettype wire

// [ifd_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                  clk_sys = 1'b0;
    logic                  arst_n = 1'b0;
    logic                  skip_next = 1'b0;
    logic                  take_branch = 1'b0;
    logic                  load_target = 1'b0;
    logic [20:0]           target_pc = 21'h000000;
    logic [20:0]           mem_addr_ff;
    logic [20:0]           pc_ff;
    logic [7:0]            mem_rdata;
    logic                  dec_valid_ff;
    ifd_pkg::ifd_decoded_s dec_ff;
    int                    miscompares = 0;
    int                    comparisons = 0;
    int                    cycles = 0;
    logic [15:0]           prog [18] = '{16'h0E55, 16'hC123, 16'hF456, 16'hEE10, 16'hF0AB, 16'h2400, 16'h6600,
        16'hC123, 16'hF456, 16'hFABC, 16'hD001, 16'h0000, 16'hE0FF, 16'hD000, 16'hEF00, 16'hF001, 16'hEC80, 16'hF002};

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    ifd_fetch_decode dut (.clk_sys(clk_sys), .arst_n(arst_n), .mem_addr_ff(mem_addr_ff), .mem_rdata(mem_rdata),
        .skip_next(skip_next), .take_branch(take_branch), .load_target(load_target), .target_pc(target_pc),
        .dec_valid_ff(dec_valid_ff), .dec_ff(dec_ff), .pc_ff(pc_ff));
    ifd_prog_mem mem (.mem_addr(mem_addr_ff), .mem_rdata(mem_rdata));

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is under 100 words, so a hang shows long before this
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 600) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Controls are held through the EXEC cycle only, which follows the odd-byte fetch
    // The first negedge wait lets a call made at a clock edge see the address that edge launched
    task automatic word(input logic s, input logic b, input logic l, input logic [20:0] t);
        @(negedge clk_sys);
        while (mem_addr_ff[0] !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        skip_next <= s;
        take_branch <= b;
        load_target <= l;
        target_pc <= t;
        @(posedge clk_sys);
        skip_next <= 1'b0;
        take_branch <= 1'b0;
        load_target <= 1'b0;
    endtask

    // Literal is checked for every kind; words outside a pair carry zero
    task automatic expect_dec(input ifd_pkg::ifd_kind_e k, input logic [11:0] lit, input logic [20:0] pc);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (dec_valid_ff !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        chk(21'(dec_valid_ff), 21'h000001);
        chk(21'(dec_ff.kind), 21'(k));
        chk(21'(dec_ff.literal), 21'(lit));
        chk(pc_ff, pc);
    endtask

    task automatic t_pairs();
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_SINGLE, 0, 21'h000002);
        word(0, 0, 0, 0); word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_MOVE_FF, 12'h456, 21'h000006);
        chk(21'(dec_ff.first_word), 21'h00C123);
        word(0, 0, 0, 0); word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_LOAD_FSR, 12'h0AB, 21'h00000A);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_SINGLE, 0, 21'h00000C);
        $display("pairs test done");
    endtask

    task automatic t_skip();
        word(1, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_SINGLE, 0, 21'h00000E);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_NOP, 0, 21'h000010);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_NOP, 0, 21'h000012);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_NOP, 0, 21'h000014);
        $display("skip test done");
    endtask

    task automatic t_branch();
        word(0, 1, 0, 0); expect_dec(ifd_pkg::IFD_K_BRANCH, 0, 21'h000018);
        chk(dec_ff.target, 21'h000018);
        word(0, 1, 0, 0); expect_dec(ifd_pkg::IFD_K_BRANCH, 0, 21'h000018);
        chk(dec_ff.target, 21'h000018);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_BRANCH, 0, 21'h00001A);
        chk(dec_ff.target, 21'h000018);
        word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_BRANCH, 0, 21'h00001C);
        $display("branch test done");
    endtask

    task automatic t_jumps();
        word(0, 0, 0, 0); word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_GOTO, 12'h001, 21'h000200);
        chk(dec_ff.target, 21'h000200);
        word(0, 0, 1, 21'h000021); expect_dec(ifd_pkg::IFD_K_SINGLE, 0, 21'h000020);
        word(0, 0, 0, 0); word(0, 0, 0, 0); expect_dec(ifd_pkg::IFD_K_CALL, 12'h002, 21'h000500);
        chk(dec_ff.target, 21'h000500);
        $display("jumps test done");
    endtask

    // Load the image, hold reset for six cycles, then run
    initial begin
        for (int i = 0; i < 18; i++) begin
            mem.bytes_q[2 * i] = prog[i][7:0];
            mem.bytes_q[2 * i + 1] = prog[i][15:8];
        end
        for (int i = 36; i < 64; i++) mem.bytes_q[i] = 8'h00;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_pairs();
        t_skip();
        t_branch();
        t_jumps();
        finish_test();
    end
endmodule // testbench

bind ifd_fetch_decode ifd_fetch_decode_props props (.clk_sys(clk_sys), .arst_n(arst_n), .mem_addr_ff(mem_addr_ff),
    .dec_valid_ff(dec_valid_ff), .dec_ff(dec_ff), .pc_ff(pc_ff));

`default_nettype wire
